//--- csr_special_regs.sv
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
// Operation
// RULE_01: stack pointer banked; process pointer only user thread
// RULE_02: main pointer used in all other cases
// RULE_03: stack pointer low two bits forced zero
// RULE_04: subroutine call stores return address in link
// RULE_05: program counter bit zero forced zero
// RULE_06: status word readable jointly or per part
// RULE_07: condition flags in top five bits
// RULE_08: current exception number in low nine bits
// RULE_09: continuable and if-then state in two ranges
// RULE_10: state bit reads one; clearing raises fault
// RULE_11: mask-all blocks all but nonmaskable, hard fault
// RULE_12: fault-mask blocks everything but nonmaskable
// RULE_13: nonzero threshold blocks equal or higher values; code applies it only to request numbers from EXC_FIRST_IRQ up
// RULE_14: threshold zero disables threshold masking
// RULE_15: control bit zero selects thread privilege
// RULE_16: control bit one selects alternate stack
// RULE_17: stack-select bit zero in handler mode
// RULE_18: handler mode while servicing exception, privileged
// RULE_19: user access to restricted registers faults
// RULE_20: masks and control reset to zero
module csr_special_regs
  import csr_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire csr_bus_t bus_i,
  input wire csr_core_t core_i,
  output logic [31:0] rdata_o,
  output logic fault_o,
  output logic [31:0] active_sp_o,
  output logic [31:0] pc_o,
  output logic [31:0] lr_o,
  output logic [31:0] psw_o,
  output logic handler_o,
  output logic privileged_o,
  output logic req_allowed_o
);

  logic [1:0] rst_sync_reg;
  logic rst_n;
  csr_state_t s_reg;
  csr_state_t s_next;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  function automatic logic [31:0] psw_pack(input csr_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[31:FLAGS_LSB] = s.flags; // RULE_07
    w[26:ITB_LSB] = s.itb; // RULE_09
    w[TBIT_POS] = 1'b1; // RULE_10
    w[15:ICT_LSB] = s.ict; // RULE_09
    w[8:0] = s.exc_num; // RULE_08
    return w;
  endfunction : psw_pack

  // process pointer only for user level in thread mode
  function automatic logic use_proc_sp(input logic [8:0] num, input logic [1:0] ctrl);
    return (num == EXC_THREAD) && ctrl[CTRL_USER] && ctrl[CTRL_SPSEL]; // RULE_01 RULE_02
  endfunction : use_proc_sp

  // registers a user-level thread may still touch
  function automatic logic restricted(input logic [7:0] a);
    logic r;
    r = 1'b1;
    if (a == OFF_ACT_SP) begin
      r = 1'b0;
    end else if (a == OFF_PROC_SP) begin
      r = 1'b0;
    end else if (a == OFF_LR) begin
      r = 1'b0;
    end else if (a == OFF_PC) begin
      r = 1'b0;
    end else if (a == OFF_FLAGS) begin
      r = 1'b0;
    end else if (a == OFF_MODE) begin
      r = 1'b0;
    end
    return r;
  endfunction : restricted

  function automatic logic req_ok(input logic [8:0] num, input logic [8:0] pri,
                                  input logic pm, input logic fm, input logic [8:0] bp);
    logic ok;
    ok = 1'b1;
    if (num == EXC_NMI) begin
      ok = 1'b1;
    end else if (fm) begin
      ok = 1'b0; // RULE_12
    end else if (num == EXC_HARD) begin
      ok = 1'b1; // RULE_11
    end else if (pm) begin
      ok = 1'b0; // RULE_11
    end else if ((bp != RST_BPRI) && (num >= EXC_FIRST_IRQ) && (pri >= bp)) begin
      ok = 1'b0; // RULE_13 RULE_14
    end
    return ok;
  endfunction : req_ok

  always_comb begin
    logic handler;
    logic user;
    logic sel_proc;
    logic [31:0] psw;
    logic [31:0] w;
    handler = (s_reg.exc_num != EXC_THREAD); // RULE_18
    user = !handler && s_reg.ctrl[CTRL_USER]; // RULE_15
    sel_proc = use_proc_sp(s_reg.exc_num, s_reg.ctrl);
    psw = psw_pack(s_reg);
    w = bus_i.wdata;
    s_next = s_reg;
    s_next.fault = 1'b0;
    s_next.rdata = RST_WORD;

    // software read, data shown one cycle later
    if (bus_i.re) begin
      if (user && restricted(bus_i.addr)) begin
        s_next.fault = 1'b1; // RULE_19
      end else if (bus_i.addr == OFF_ACT_SP) begin
        s_next.rdata = sel_proc ? s_reg.proc_sp : s_reg.main_sp;
      end else if (bus_i.addr == OFF_MAIN_SP) begin
        s_next.rdata = s_reg.main_sp;
      end else if (bus_i.addr == OFF_PROC_SP) begin
        s_next.rdata = s_reg.proc_sp;
      end else if (bus_i.addr == OFF_LR) begin
        s_next.rdata = s_reg.lr;
      end else if (bus_i.addr == OFF_PC) begin
        s_next.rdata = s_reg.pc;
      end else if (bus_i.addr == OFF_PSW) begin
        s_next.rdata = psw; // RULE_06
      end else if (bus_i.addr == OFF_FLAGS) begin
        s_next.rdata = psw & PSW_FLAGS_MASK; // RULE_06
      end else if (bus_i.addr == OFF_NUM) begin
        s_next.rdata = psw & PSW_NUM_MASK; // RULE_06
      end else if (bus_i.addr == OFF_EXEC) begin
        s_next.rdata = psw & PSW_EXEC_MASK; // RULE_06
      end else if (bus_i.addr == OFF_PMASK) begin
        s_next.rdata = {31'h0000_0000, s_reg.pmask};
      end else if (bus_i.addr == OFF_FMASK) begin
        s_next.rdata = {31'h0000_0000, s_reg.fmask};
      end else if (bus_i.addr == OFF_BPRI) begin
        s_next.rdata = {23'h00_0000, s_reg.bpri};
      end else if (bus_i.addr == OFF_CTRL) begin
        s_next.rdata = {30'h0000_0000, s_reg.ctrl};
      end else if (bus_i.addr == OFF_MODE) begin
        s_next.rdata = {30'h0000_0000, !user, handler};
      end
    end

    // software write
    if (bus_i.we) begin
      if (user && restricted(bus_i.addr)) begin
        s_next.fault = 1'b1; // RULE_19
      end else if (bus_i.addr == OFF_ACT_SP) begin
        if (sel_proc) begin
          s_next.proc_sp = w & SP_ALIGN_MASK; // RULE_03
        end else begin
          s_next.main_sp = w & SP_ALIGN_MASK; // RULE_03
        end
      end else if (bus_i.addr == OFF_MAIN_SP) begin
        s_next.main_sp = w & SP_ALIGN_MASK; // RULE_03
      end else if (bus_i.addr == OFF_PROC_SP) begin
        s_next.proc_sp = w & SP_ALIGN_MASK; // RULE_03
      end else if (bus_i.addr == OFF_LR) begin
        s_next.lr = w;
      end else if (bus_i.addr == OFF_PC) begin
        s_next.pc = w & PC_ALIGN_MASK; // RULE_05
      end else if (bus_i.addr == OFF_FLAGS) begin
        s_next.flags = w[31:FLAGS_LSB]; // RULE_07
      end else if ((bus_i.addr == OFF_PSW) || (bus_i.addr == OFF_EXEC)) begin
        if (bus_i.addr == OFF_PSW) begin
          s_next.flags = w[31:FLAGS_LSB]; // RULE_06
        end
        // a cleared state bit rejects the whole execution part
        if (!w[TBIT_POS]) begin
          s_next.fault = 1'b1; // RULE_10
        end else begin
          s_next.itb = w[26:ITB_LSB]; // RULE_09
          s_next.ict = w[15:ICT_LSB]; // RULE_09
        end
      end else if (bus_i.addr == OFF_PMASK) begin
        s_next.pmask = w[0];
      end else if (bus_i.addr == OFF_FMASK) begin
        s_next.fmask = w[0];
      end else if (bus_i.addr == OFF_BPRI) begin
        s_next.bpri = w[8:0];
      end else if (bus_i.addr == OFF_CTRL) begin
        s_next.ctrl[CTRL_USER] = w[CTRL_USER]; // RULE_15
        s_next.ctrl[CTRL_SPSEL] = handler ? 1'b0 : w[CTRL_SPSEL]; // RULE_16 RULE_17
      end
    end

    // core updates take precedence over software writes
    if (core_i.sp_we) begin
      if (sel_proc) begin
        s_next.proc_sp = core_i.sp & SP_ALIGN_MASK; // RULE_03
      end else begin
        s_next.main_sp = core_i.sp & SP_ALIGN_MASK; // RULE_03
      end
    end
    if (core_i.pc_we) begin
      s_next.pc = core_i.pc & PC_ALIGN_MASK; // RULE_05
    end
    if (core_i.call) begin
      s_next.lr = core_i.ret_addr; // RULE_04
    end
    if (core_i.flags_we) begin
      s_next.flags = core_i.flags; // RULE_07
    end

    // exception entry and return; stack select held aside while in handler
    if (core_i.exc_enter && (core_i.exc_num != EXC_THREAD)) begin
      if (!handler) begin
        s_next.saved_spsel = s_next.ctrl[CTRL_SPSEL];
      end
      s_next.exc_num = core_i.exc_num; // RULE_08 RULE_18
      s_next.ctrl[CTRL_SPSEL] = 1'b0; // RULE_17
    end else if (core_i.exc_return) begin
      s_next.exc_num = core_i.exc_num; // RULE_18
      if (core_i.exc_num == EXC_THREAD) begin
        s_next.ctrl[CTRL_SPSEL] = s_reg.saved_spsel; // RULE_16
      end else begin
        s_next.ctrl[CTRL_SPSEL] = 1'b0; // RULE_17
      end
    end

    // masking judged on current masks, one cycle of latency
    s_next.allow = core_i.req_valid &&
                   req_ok(core_i.req_num, core_i.req_pri, s_reg.pmask, s_reg.fmask, s_reg.bpri);

    s_next.handler = (s_next.exc_num != EXC_THREAD); // RULE_18
    s_next.privileged = s_next.handler || !s_next.ctrl[CTRL_USER]; // RULE_15 RULE_18
    s_next.act_sp = use_proc_sp(s_next.exc_num, s_next.ctrl) ? s_next.proc_sp :
                    s_next.main_sp; // RULE_01
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_reg.main_sp <= RST_WORD;
      s_reg.proc_sp <= RST_WORD;
      s_reg.lr <= RST_WORD;
      s_reg.pc <= RST_WORD;
      s_reg.flags <= 5'h00;
      s_reg.exc_num <= EXC_THREAD;
      s_reg.ict <= 6'h00;
      s_reg.itb <= 2'h0;
      s_reg.pmask <= 1'b0; // RULE_20
      s_reg.fmask <= 1'b0; // RULE_20
      s_reg.bpri <= RST_BPRI; // RULE_20
      s_reg.ctrl <= RST_CTRL; // RULE_20
      s_reg.saved_spsel <= 1'b0;
      s_reg.rdata <= RST_WORD;
      s_reg.fault <= 1'b0;
      s_reg.allow <= 1'b0;
      s_reg.act_sp <= RST_WORD;
      s_reg.handler <= 1'b0;
      s_reg.privileged <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_o = s_reg.rdata;
  assign fault_o = s_reg.fault;
  assign active_sp_o = s_reg.act_sp;
  assign pc_o = s_reg.pc;
  assign lr_o = s_reg.lr;
  assign handler_o = s_reg.handler;
  assign privileged_o = s_reg.privileged;
  assign req_allowed_o = s_reg.allow;

  // status word built from flops only; the pack is plain wiring
  assign psw_o = psw_pack(s_reg);

endmodule : csr_special_regs

//--- csr_pkg.sv
package csr_pkg;

  localparam int ADDR_W = 8;

  // word-aligned register offsets
  localparam logic [7:0] OFF_ACT_SP = 8'h00;
  localparam logic [7:0] OFF_MAIN_SP = 8'h04;
  localparam logic [7:0] OFF_PROC_SP = 8'h08;
  localparam logic [7:0] OFF_LR = 8'h0c;
  localparam logic [7:0] OFF_PC = 8'h10;
  localparam logic [7:0] OFF_PSW = 8'h14;
  localparam logic [7:0] OFF_FLAGS = 8'h18;
  localparam logic [7:0] OFF_NUM = 8'h1c;
  localparam logic [7:0] OFF_EXEC = 8'h20;
  localparam logic [7:0] OFF_PMASK = 8'h24;
  localparam logic [7:0] OFF_FMASK = 8'h28;
  localparam logic [7:0] OFF_BPRI = 8'h2c;
  localparam logic [7:0] OFF_CTRL = 8'h30;
  localparam logic [7:0] OFF_MODE = 8'h34;

  // status word field and control bit positions
  localparam int FLAGS_LSB = 27;
  localparam int ITB_LSB = 25;
  localparam int TBIT_POS = 24;
  localparam int ICT_LSB = 10;
  localparam int CTRL_USER = 0;
  localparam int CTRL_SPSEL = 1;

  localparam logic [31:0] PSW_FLAGS_MASK = 32'hf800_0000;
  localparam logic [31:0] PSW_EXEC_MASK = 32'h0700_fc00;
  localparam logic [31:0] PSW_NUM_MASK = 32'h0000_01ff;
  localparam logic [31:0] SP_ALIGN_MASK = 32'hffff_fffc;
  localparam logic [31:0] PC_ALIGN_MASK = 32'hffff_fffe;

  localparam logic [8:0] EXC_THREAD = 9'h000;
  localparam logic [8:0] EXC_NMI = 9'h002;
  localparam logic [8:0] EXC_HARD = 9'h003;
  localparam logic [8:0] EXC_FIRST_IRQ = 9'h010;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [8:0] RST_BPRI = 9'h000;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } csr_bus_t;

  typedef struct packed {
    logic sp_we;
    logic [31:0] sp;
    logic pc_we;
    logic [31:0] pc;
    logic call;
    logic [31:0] ret_addr;
    logic flags_we;
    logic [4:0] flags;
    logic exc_enter;
    logic exc_return;
    logic [8:0] exc_num;
    logic req_valid;
    logic [8:0] req_num;
    logic [8:0] req_pri;
  } csr_core_t;

  typedef struct packed {
    logic [31:0] main_sp;
    logic [31:0] proc_sp;
    logic [31:0] lr;
    logic [31:0] pc;
    logic [4:0] flags;
    logic [8:0] exc_num;
    logic [5:0] ict;
    logic [1:0] itb;
    logic pmask;
    logic fmask;
    logic [8:0] bpri;
    logic [1:0] ctrl;
    logic saved_spsel;
    logic [31:0] rdata;
    logic fault;
    logic allow;
    logic [31:0] act_sp;
    logic handler;
    logic privileged;
  } csr_state_t;

endpackage : csr_pkg

//--- csr_special_regs_assertions.sv
`timescale 1ns/1ps
module csr_special_regs_assertions
  import csr_pkg::*;
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire csr_bus_t bus_i,
  input wire csr_core_t core_i,
  input wire logic [31:0] rdata_o,
  input wire logic fault_o,
  input wire logic [31:0] active_sp_o,
  input wire logic [31:0] pc_o,
  input wire logic [31:0] lr_o,
  input wire logic [31:0] psw_o,
  input wire logic handler_o,
  input wire logic privileged_o,
  input wire logic req_allowed_o
);
  // outputs lag release by two sync edges
  logic [1:0] up_reg;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      up_reg <= 2'h0;
    end else if (up_reg != 2'h3) begin
      up_reg <= up_reg + 2'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (up_reg != 2'h3);
  a_sp_word_align: assert property (active_sp_o[1:0] == 2'h0)
    else $error("sp align");
  a_pc_half_align: assert property (pc_o[0] == 1'h0)
    else $error("pc align");
  a_state_bit_one: assert property (psw_o[24])
    else $error("state bit");
  a_call_to_link: assert property (core_i.call |=> lr_o == $past(core_i.ret_addr))
    else $error("link");
  a_flags_written: assert property (core_i.flags_we |=> psw_o[31:27] == $past(core_i.flags))
    else $error("flags");
  a_enter_number: assert property (core_i.exc_enter && core_i.exc_num != 9'h0 |=>
    handler_o && psw_o[8:0] == $past(core_i.exc_num)) else $error("exc number");
  a_handler_priv: assert property (handler_o == (psw_o[8:0] != 9'h0)
    && (!handler_o || privileged_o)) else $error("handler");
  a_nmi_passes: assert property (core_i.req_valid && core_i.req_num == EXC_NMI |=> req_allowed_o)
    else $error("nmi");
  a_allow_needs_req: assert property (req_allowed_o |-> $past(core_i.req_valid))
    else $error("allow");
  a_read_one_cycle: assert property (rdata_o != 32'h0 |-> $past(bus_i.re))
    else $error("rdata");
  a_fault_cause: assert property (fault_o |-> $past(bus_i.we || bus_i.re))
    else $error("fault");
  c_enter: cover property (core_i.exc_enter ##1 handler_o);
  c_fault: cover property (fault_o);
  c_block: cover property (core_i.req_valid ##1 !req_allowed_o);
endmodule : csr_special_regs_assertions

bind csr_special_regs csr_special_regs_assertions u_chk (.clk_i, .resetn_i, .bus_i, .core_i,
  .rdata_o, .fault_o, .active_sp_o, .pc_o, .lr_o, .psw_o, .handler_o, .privileged_o,
  .req_allowed_o);

//--- tb_csr_special_regs.sv
`timescale 1ns/1ps
module tb_csr_special_regs
  import csr_pkg::*;
;
  logic clk_i = 1'h0;
  logic resetn_i;
  csr_bus_t bus_i = '0;
  csr_core_t core_i = '0;
  logic [31:0] rdata_o, active_sp_o, pc_o, lr_o, psw_o, d;
  logic fault_o, handler_o, privileged_o, req_allowed_o, f;
  int n_fail = 0;
  int n_compared = 0;
  always #20 clk_i = ~clk_i;
  csr_special_regs DUT (.clk_i, .resetn_i, .bus_i, .core_i, .rdata_o, .fault_o, .active_sp_o,
    .pc_o, .lr_o, .psw_o, .handler_o, .privileged_o, .req_allowed_o);

  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", w, exp, seen);
    end
  endtask : check

  task automatic print_verdict;
    if (n_fail == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    bus_i.we <= 1'h1;
    bus_i.addr <= a;
    bus_i.wdata <= v;
    @(posedge clk_i);
    bus_i.we <= 1'h0;
    #1 f = fault_o;
  endtask : wr

  // read data stand one cycle only, so grab them at once
  task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_i);
    bus_i.re <= 1'h1;
    bus_i.addr <= a;
    @(posedge clk_i);
    bus_i.re <= 1'h0;
    #1 d = rdata_o;
    f = fault_o;
    check(w, d, exp);
  endtask : rchk

  task automatic pulse(input csr_core_t c);
    @(posedge clk_i);
    core_i <= c;
    @(posedge clk_i);
    core_i <= '0;
    #1;
  endtask : pulse

  task automatic t_reset;
    rchk("pmask", OFF_PMASK, 32'h0);
    rchk("ctrl", OFF_CTRL, 32'h0);
    rchk("bpri", OFF_BPRI, 32'h0);
    check("priv", {31'h0, privileged_o}, 32'h1);
    rchk("unmapped", 8'hfc, 32'h0);
  endtask : t_reset

  task automatic t_status;
    csr_core_t c;
    c = '0;
    wr(OFF_PSW, 32'h0700_fc00);
    c.flags_we = 1'h1;
    c.flags = 5'h15;
    pulse(c);
    rchk("flags", OFF_FLAGS, 32'ha800_0000);
    rchk("exec", OFF_EXEC, 32'h0700_fc00);
    rchk("word", OFF_PSW, 32'haf00_fc00);
    rchk("excnum", OFF_NUM, 32'h0);
    wr(OFF_PSW, 32'h0);
    check("clr fault", {31'h0, f}, 32'h1);
    rchk("exec kept", OFF_EXEC, 32'h0700_fc00);
    rchk("flags clr", OFF_FLAGS, 32'h0);
  endtask : t_status

  task automatic judge(input logic pm, fm, input logic [8:0] bp, n, p, input logic e);
    wr(OFF_PMASK, {31'h0, pm});
    wr(OFF_FMASK, {31'h0, fm});
    wr(OFF_BPRI, {23'h0, bp});
    @(posedge clk_i);
    core_i.req_valid <= 1'h1;
    core_i.req_num <= n;
    core_i.req_pri <= p;
    @(posedge clk_i);
    core_i <= '0;
    #1 check("allowed", {31'h0, req_allowed_o}, {31'h0, e});
  endtask : judge

  task automatic t_mask;
    judge(1'h0, 1'h0, 9'h0, 9'h20, 9'h5, 1'h1);
    judge(1'h0, 1'h0, 9'h5, 9'h20, 9'h5, 1'h0);
    judge(1'h0, 1'h0, 9'h5, 9'h20, 9'h4, 1'h1);
    judge(1'h0, 1'h0, 9'h5, 9'h0f, 9'h5, 1'h1);
    judge(1'h1, 1'h0, 9'h0, 9'h20, 9'h0, 1'h0);
    judge(1'h1, 1'h0, 9'h0, EXC_HARD, 9'h0, 1'h1);
    judge(1'h0, 1'h1, 9'h0, EXC_HARD, 9'h0, 1'h0);
    judge(1'h1, 1'h1, 9'h0, EXC_NMI, 9'h0, 1'h1);
  endtask : t_mask

  task automatic t_link;
    csr_core_t c;
    c = '0;
    c.call = 1'h1;
    c.ret_addr = 32'h0800_1235;
    c.pc_we = 1'h1;
    c.pc = 32'h0800_0123;
    pulse(c);
    check("link", lr_o, 32'h0800_1235);
    check("pc", pc_o, 32'h0800_0122);
  endtask : t_link

  task automatic t_stack;
    csr_core_t c;
    c = '0;
    wr(OFF_MAIN_SP, 32'h2000_0807);
    wr(OFF_PROC_SP, 32'h2000_0403);
    rchk("main sp", OFF_MAIN_SP, 32'h2000_0804);
    check("act main", active_sp_o, 32'h2000_0804);
    wr(OFF_CTRL, 32'h3);
    @(posedge clk_i);
    #1 check("act proc", active_sp_o, 32'h2000_0400);
    check("user", {31'h0, privileged_o}, 32'h0);
    rchk("act rd", OFF_ACT_SP, 32'h2000_0400);
    rchk("mode user", OFF_MODE, 32'h0);
    wr(OFF_PMASK, 32'h0);
    check("refused", {31'h0, f}, 32'h1);
    c.exc_enter = 1'h1;
    c.exc_num = 9'h15;
    pulse(c);
    check("hdl sp", active_sp_o, 32'h2000_0804);
    check("hdl num", {23'h0, psw_o[8:0]}, 32'h15);
    check("hdl", {30'h0, handler_o, privileged_o}, 32'h3);
    rchk("hdl mode", OFF_MODE, 32'h3);
    rchk("hdl ctrl", OFF_CTRL, 32'h1);
    c = '0;
    c.sp_we = 1'h1;
    c.sp = 32'h2000_0a0b;
    pulse(c);
    check("core sp", active_sp_o, 32'h2000_0a08);
    c = '0;
    c.exc_return = 1'h1;
    pulse(c);
    @(posedge clk_i);
    #1 check("back proc", active_sp_o, 32'h2000_0400);
  endtask : t_stack

  // second reset in mid-run, masks left set by the masking scenario
  task automatic t_rerun;
    @(posedge clk_i);
    resetn_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    rchk("fmask rst", OFF_FMASK, 32'h0);
    t_reset;
  endtask : t_rerun

  initial begin
    resetn_i <= 1'h0;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    t_reset;
    t_status;
    t_mask;
    t_rerun;
    t_link;
    t_stack;
    print_verdict;
  end

  // hang guard, far beyond the 155 or so cycles used
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    print_verdict;
  end
endmodule : tb_csr_special_regs
